// file: src/sub_swap_exec.sv
// Execution datapath for subtract-with-borrow and nibble exchange
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sub_swap_exec #(
    parameter int PHASE_DIVISOR = exec_pkg::PHASE_DIVISOR
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [11:0] mem_addr,
    output logic mem_rd_en,
    output logic mem_wr_en,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    exec_pkg::exec_state_type state_reg;
    exec_pkg::op_kind_type op_kind_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [11:0] mem_addr_reg;
    logic mem_rd_en_reg;
    logic mem_wr_en_reg;
    logic [7:0] mem_wdata_reg;
    logic ext_enable_reg;
    logic [3:0] bank_pointer_reg;
    logic [11:0] stack_base_reg;
    logic [7:0] acc_reg;
    logic [4:0] flags_reg;
    logic [4:0] flags_pend_reg;
    logic [15:0] instr_reg;
    logic illegal_reg;
    logic [7:0] operand_reg;
    logic [7:0] result_reg;
    logic result_sel_reg;

    logic phase_tick;
    logic busy;
    logic setup_phase;
    logic write_done;
    logic issue_ok;
    logic mapped;
    logic [5:0] opcode;
    logic [7:0] reg_addr;
    logic [11:0] data_address;
    logic [7:0] alu_difference;
    logic [4:0] alu_flags;
    logic [7:0] swapped;

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign mem_addr = mem_addr_reg;
    assign mem_rd_en = mem_rd_en_reg;
    assign mem_wr_en = mem_wr_en_reg;
    assign mem_wdata = mem_wdata_reg;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    assign busy = (state_reg != exec_pkg::ST_IDLE);

    phase_tick_gen #(
        .DIVISOR(PHASE_DIVISOR)
    ) u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .run(busy),
        .tick(phase_tick)
    );

    borrow_subtractor u_sub (
        .minuend(operand_reg),
        .subtrahend(acc_reg),
        .borrow_in(flags_reg[exec_pkg::FLAG_BORROW]),
        .difference(alu_difference),
        .flags(alu_flags)
    );

    assign swapped = {operand_reg[3:0], operand_reg[7:4]};

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign setup_phase = psel && !penable;
    assign write_done = psel && penable && pready_reg && pwrite;
    assign mapped = (paddr == exec_pkg::CTRL_OFFSET)
        || (paddr == exec_pkg::ACC_OFFSET)
        || (paddr == exec_pkg::FLAGS_OFFSET)
        || (paddr == exec_pkg::INSTR_OFFSET)
        || (paddr == exec_pkg::STATUS_OFFSET)
        || (paddr == exec_pkg::STACK_BASE_OFFSET);
    // A new word is refused while one is still executing
    assign issue_ok = write_done && (paddr == exec_pkg::INSTR_OFFSET) && !busy;

    // Zero wait states: ready and answer are set up during the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup_phase;
            pslverr_reg <= setup_phase && !mapped;
        end
    end

    // Read data, taken from the state at the setup edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (setup_phase && !pwrite) begin
            unique case (paddr)
                exec_pkg::CTRL_OFFSET: prdata_reg <= {20'h00000,
                    bank_pointer_reg, 7'h00, ext_enable_reg};
                exec_pkg::ACC_OFFSET: prdata_reg <= {24'h000000, acc_reg};
                exec_pkg::FLAGS_OFFSET: prdata_reg <= {27'h0000000, flags_reg};
                exec_pkg::INSTR_OFFSET: prdata_reg <= {16'h0000, instr_reg};
                exec_pkg::STATUS_OFFSET: prdata_reg <= {30'h00000000,
                    illegal_reg, busy};
                exec_pkg::STACK_BASE_OFFSET: prdata_reg <= {20'h00000,
                    stack_base_reg};
                default: prdata_reg <= 32'h00000000;
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_enable_reg <= 1'b0;
            bank_pointer_reg <= exec_pkg::BANK_RESET;
            stack_base_reg <= exec_pkg::STACK_BASE_RESET;
        end else if (write_done && paddr == exec_pkg::CTRL_OFFSET) begin
            ext_enable_reg <= pwdata[exec_pkg::CTRL_EXT_BIT];
            bank_pointer_reg <= pwdata[exec_pkg::CTRL_BANK_LSB +: 4];
        end else if (write_done && paddr == exec_pkg::STACK_BASE_OFFSET) begin
            stack_base_reg <= pwdata[11:0];
        end
    end

    // Instruction word and unknown-opcode flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_reg <= exec_pkg::INSTR_RESET;
            illegal_reg <= 1'b0;
        end else if (issue_ok) begin
            instr_reg <= pwdata[15:0];
            illegal_reg <= 1'b0;
        end else if (state_reg == exec_pkg::ST_DECODE && phase_tick
            && opcode != exec_pkg::SUB_BORROW_OPCODE
            && opcode != exec_pkg::NIBBLE_EXCHANGE_OPCODE) begin
            illegal_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Decode and address formation
    // ------------------------------------------------------------
    assign opcode = instr_reg[exec_pkg::OPC_LSB +: 6];
    assign reg_addr = instr_reg[7:0];

    // Banked, stack-relative or shared page, in that order of test
    always_comb begin
        if (instr_reg[exec_pkg::MEM_SEL_BIT]) begin
            data_address = {bank_pointer_reg, reg_addr};
        end else if (ext_enable_reg
            && reg_addr <= exec_pkg::STACK_REL_LIMIT) begin
            data_address = stack_base_reg + {4'h0, reg_addr};
        end else if (reg_addr < exec_pkg::SHARED_SPLIT) begin
            data_address = {exec_pkg::SHARED_LOW_PAGE, reg_addr};
        end else begin
            data_address = {exec_pkg::SHARED_HIGH_PAGE, reg_addr};
        end
    end

    // ------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------
    // One phase per tick; a word decoded as neither opcode stops early
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= exec_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                exec_pkg::ST_IDLE: begin
                    if (issue_ok) begin
                        state_reg <= exec_pkg::ST_DECODE;
                    end
                end
                exec_pkg::ST_DECODE: begin
                    if (phase_tick) begin
                        if (opcode == exec_pkg::SUB_BORROW_OPCODE
                            || opcode == exec_pkg::NIBBLE_EXCHANGE_OPCODE) begin
                            state_reg <= exec_pkg::ST_READ;
                        end else begin
                            state_reg <= exec_pkg::ST_IDLE;
                        end
                    end
                end
                exec_pkg::ST_READ: begin
                    if (phase_tick) begin
                        state_reg <= exec_pkg::ST_PROCESS;
                    end
                end
                exec_pkg::ST_PROCESS: begin
                    if (phase_tick) begin
                        state_reg <= exec_pkg::ST_WRITE;
                    end
                end
                exec_pkg::ST_WRITE: begin
                    if (phase_tick) begin
                        state_reg <= exec_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Opcode match and destination select, latched in the decode phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_kind_reg <= exec_pkg::OP_NONE;
            result_sel_reg <= 1'b1;
        end else if (state_reg == exec_pkg::ST_DECODE && phase_tick) begin
            result_sel_reg <= instr_reg[exec_pkg::RESULT_SEL_BIT];
            if (opcode == exec_pkg::SUB_BORROW_OPCODE) begin
                op_kind_reg <= exec_pkg::OP_SUB_BORROW;
            end else if (opcode == exec_pkg::NIBBLE_EXCHANGE_OPCODE) begin
                op_kind_reg <= exec_pkg::OP_NIBBLE_EXCHANGE;
            end else begin
                op_kind_reg <= exec_pkg::OP_NONE;
            end
        end
    end

    // Register file read: strobe for one cycle at the start of read phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_addr_reg <= 12'h000;
            mem_rd_en_reg <= 1'b0;
            operand_reg <= 8'h00;
        end else if (state_reg == exec_pkg::ST_DECODE && phase_tick
            && (opcode == exec_pkg::SUB_BORROW_OPCODE
            || opcode == exec_pkg::NIBBLE_EXCHANGE_OPCODE)) begin
            mem_addr_reg <= data_address;
            mem_rd_en_reg <= 1'b1;
        end else if (mem_rd_en_reg) begin
            operand_reg <= mem_rdata;
            mem_rd_en_reg <= 1'b0;
        end
    end

    // Process phase: the operand is stable here, so the result is latched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= 8'h00;
            flags_pend_reg <= exec_pkg::FLAGS_RESET;
        end else if (state_reg == exec_pkg::ST_PROCESS && phase_tick) begin
            if (op_kind_reg == exec_pkg::OP_SUB_BORROW) begin
                result_reg <= alu_difference;
                flags_pend_reg <= alu_flags;
            end else begin
                result_reg <= swapped;
            end
        end
    end

    // Write phase toward the register file; the strobe lasts one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_wr_en_reg <= 1'b0;
            mem_wdata_reg <= 8'h00;
        end else if (state_reg == exec_pkg::ST_WRITE && phase_tick
            && result_sel_reg) begin
            mem_wr_en_reg <= 1'b1;
            mem_wdata_reg <= result_reg;
        end else begin
            mem_wr_en_reg <= 1'b0;
        end
    end

    // Accumulator; software writes are ignored while busy to avoid a race
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= exec_pkg::ACC_RESET;
        end else if (state_reg == exec_pkg::ST_WRITE && phase_tick
            && !result_sel_reg) begin
            acc_reg <= result_reg;
        end else if (!busy && write_done
            && paddr == exec_pkg::ACC_OFFSET) begin
            acc_reg <= pwdata[7:0];
        end
    end

    // Status flags change only for the subtract or a software write while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= exec_pkg::FLAGS_RESET;
        end else if (state_reg == exec_pkg::ST_WRITE && phase_tick
            && op_kind_reg == exec_pkg::OP_SUB_BORROW) begin
            flags_reg <= flags_pend_reg;
        end else if (!busy && write_done
            && paddr == exec_pkg::FLAGS_OFFSET) begin
            flags_reg <= pwdata[exec_pkg::FLAG_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam int BUSY_LAST = exec_pkg::PHASES_PER_CYCLE * PHASE_DIVISOR - 1;
    logic [15:0] busy_cnt;
    logic op_legal;

    // Word matches one of the two opcodes, so a memory read must follow
    assign op_legal = (opcode == exec_pkg::SUB_BORROW_OPCODE)
        || (opcode == exec_pkg::NIBBLE_EXCHANGE_OPCODE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt <= 16'h0000;
        end else if (busy) begin
            busy_cnt <= busy_cnt + 16'h0001;
        end else begin
            busy_cnt <= 16'h0000;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_process_tick;
        state_reg == exec_pkg::ST_PROCESS && phase_tick;
    endsequence
    sequence s_write_tick;
        state_reg == exec_pkg::ST_WRITE && phase_tick;
    endsequence
    sequence s_decode_tick;
        state_reg == exec_pkg::ST_DECODE && phase_tick;
    endsequence

    AST_SUB_RESULT: assert property (
        s_process_tick and op_kind_reg == exec_pkg::OP_SUB_BORROW
        |=> result_reg == 8'($past(operand_reg) - $past(acc_reg)
            - {7'h00, ~$past(flags_reg[exec_pkg::FLAG_BORROW])}))
        else $error("subtract result wrong");
    AST_BORROW_SENSE: assert property (
        s_process_tick and op_kind_reg == exec_pkg::OP_SUB_BORROW
        |=> flags_pend_reg[exec_pkg::FLAG_BORROW]
            == ({1'b0, $past(operand_reg)} >= {1'b0, $past(acc_reg)}
            + {8'h00, ~$past(flags_reg[exec_pkg::FLAG_BORROW])}))
        else $error("borrow flag sense wrong");
    AST_OPCODE_MATCH: assert property (
        s_decode_tick |=> (op_kind_reg == exec_pkg::OP_SUB_BORROW)
            == ($past(opcode) == exec_pkg::SUB_BORROW_OPCODE))
        else $error("subtract opcode decode wrong");
    AST_ACC_DEST: assert property (
        s_write_tick and !result_sel_reg
        |=> acc_reg == $past(result_reg) && !mem_wr_en_reg)
        else $error("accumulator destination wrong");
    AST_REG_DEST: assert property (
        s_write_tick and result_sel_reg
        |=> mem_wr_en_reg && mem_wdata == $past(result_reg)
            && $stable(acc_reg) ##1 !mem_wr_en_reg)
        else $error("register destination wrong");
    AST_BANKED_ADDR: assert property (
        s_decode_tick and instr_reg[exec_pkg::MEM_SEL_BIT] and op_legal
        |=> mem_rd_en_reg && mem_addr_reg
            == {$past(bank_pointer_reg), $past(reg_addr)})
        else $error("banked address wrong");
    AST_STACK_REL: assert property (
        s_decode_tick and !instr_reg[exec_pkg::MEM_SEL_BIT] and op_legal
        and ext_enable_reg and reg_addr <= exec_pkg::STACK_REL_LIMIT
        |=> mem_rd_en_reg && mem_addr_reg
            == 12'($past(stack_base_reg) + {4'h0, $past(reg_addr)}))
        else $error("stack relative address wrong");
    AST_ONE_CYCLE: assert property (
        busy |-> busy_cnt <= 16'(BUSY_LAST))
        else $error("instruction cycle overran");
    AST_PHASE_ORDER: assert property (
        s_decode_tick |=> state_reg == ($past(op_legal)
            ? exec_pkg::ST_READ : exec_pkg::ST_IDLE))
        else $error("decode not followed by read");
    AST_SWAP: assert property (
        s_process_tick and op_kind_reg == exec_pkg::OP_NIBBLE_EXCHANGE
        |=> result_reg == {$past(operand_reg[3:0]), $past(operand_reg[7:4])})
        else $error("nibble exchange wrong");
    AST_SWAP_FLAGS: assert property (
        s_write_tick and op_kind_reg == exec_pkg::OP_NIBBLE_EXCHANGE
        |=> $stable(flags_reg))
        else $error("swap changed flags");
endmodule
`default_nettype wire

// file: src/exec_pkg.sv
// Constants and types shared by the subtract/swap execution datapath
package exec_pkg;

    // ------------------------------------------------------------
    // Register byte offsets on the APB slave
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] ACC_OFFSET = 8'h04;
    localparam logic [7:0] FLAGS_OFFSET = 8'h08;
    localparam logic [7:0] INSTR_OFFSET = 8'h0C;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    localparam logic [7:0] STACK_BASE_OFFSET = 8'h14;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_BANK_LSB = 8;
    localparam int BANK_W = 4;
    localparam int DATA_ADDR_W = 12;
    localparam int FLAG_W = 5;
    localparam int FLAG_BORROW = 0;
    localparam int FLAG_HALF = 1;
    localparam int FLAG_CLEAR = 2;
    localparam int FLAG_WRAP = 3;
    localparam int FLAG_MSB = 4;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_ILLEGAL_BIT = 1;
    localparam int OPC_LSB = 10;
    localparam int RESULT_SEL_BIT = 9;
    localparam int MEM_SEL_BIT = 8;

    // ------------------------------------------------------------
    // Opcodes and address decode limits
    // ------------------------------------------------------------
    localparam logic [5:0] SUB_BORROW_OPCODE = 6'h16;
    localparam logic [5:0] NIBBLE_EXCHANGE_OPCODE = 6'h0E;
    localparam logic [7:0] STACK_REL_LIMIT = 8'h5F;
    localparam logic [7:0] SHARED_SPLIT = 8'h60;
    localparam logic [3:0] SHARED_LOW_PAGE = 4'h0;
    localparam logic [3:0] SHARED_HIGH_PAGE = 4'hF;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam logic [11:0] STACK_BASE_RESET = 12'h000;
    localparam logic [15:0] INSTR_RESET = 16'h0000;
    localparam int PHASE_DIVISOR = 1;
    localparam int PHASES_PER_CYCLE = 4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DECODE,
        ST_READ,
        ST_PROCESS,
        ST_WRITE
    } exec_state_type;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_SUB_BORROW,
        OP_NIBBLE_EXCHANGE
    } op_kind_type;

endpackage

// file: src/phase_tick_gen.sv
// Divider giving one enable pulse per instruction phase
`timescale 1ns/1ns
`default_nettype none
module phase_tick_gen #(
    parameter int DIVISOR = exec_pkg::PHASE_DIVISOR
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output logic tick
);
    localparam int CW = $clog2(DIVISOR + 1);
    localparam logic [CW-1:0] LAST = CW'(DIVISOR - 1);

    logic [CW-1:0] count_reg;

    // Restart while idle so the first phase of an instruction is full length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else if (!run || count_reg == LAST) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign tick = run && (count_reg == LAST);
endmodule
`default_nettype wire

// file: src/borrow_subtractor.sv
// Eight-bit subtract with borrow and its status flags
`timescale 1ns/1ns
`default_nettype none
module borrow_subtractor (
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    input wire logic borrow_in,
    output logic [7:0] difference,
    output logic [4:0] flags
);
    logic [8:0] full_sum;
    logic [4:0] low_sum;

    // Adding the inverse plus carry is the two's complement subtract
    assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, borrow_in};
    assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]}
        + {4'h0, borrow_in};
    assign difference = full_sum[7:0];

    // Carry out set means no borrow was taken
    always_comb begin
        flags = exec_pkg::FLAGS_RESET;
        flags[exec_pkg::FLAG_BORROW] = full_sum[8];
        flags[exec_pkg::FLAG_HALF] = low_sum[4];
        flags[exec_pkg::FLAG_CLEAR] = (full_sum[7:0] == 8'h00);
        flags[exec_pkg::FLAG_WRAP] = (minuend[7] != subtrahend[7])
            && (full_sum[7] != minuend[7]);
        flags[exec_pkg::FLAG_MSB] = full_sum[7];
    end
endmodule
`default_nettype wire

// file: verif/data_mem_model.sv
// Byte-wide data-memory model on the far side of the datapath
`timescale 1ns/1ns
`default_nettype none
module data_mem_model (
    input wire logic pclk,
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd_en,
    input wire logic mem_wr_en,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [4096];
    // Seed from the address so neighbouring bytes differ
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i * 7 + (i >> 8));
        end
    end
    // Write lands at the edge that ends the enable pulse
    always @(posedge pclk) begin
        if (mem_wr_en) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
    // Outside a read the data is inverted, so a late capture shows up
    assign mem_rdata = mem_rd_en ? mem[mem_addr] : ~mem[mem_addr];
endmodule
`default_nettype wire

// file: verif/sub_swap_exec_tb_top.sv
// Register-level bench for the subtract/swap datapath
`timescale 1ns/1ns
`default_nettype none
module sub_swap_exec_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, mrd;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, rd, wr;
    logic [11:0] ma;
    logic [7:0] mwd;
    int err_count = 0, n_tests = 0;
    initial forever #4 pclk = ~pclk;
    sub_swap_exec #(.PHASE_DIVISOR(1)) sub_swap_exec_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_addr(ma), .mem_rd_en(rd), .mem_wr_en(wr),
        .mem_wdata(mwd), .mem_rdata(mrd));
    data_mem_model data_mem_model_i (.pclk(pclk), .mem_addr(ma),
        .mem_rd_en(rd), .mem_wr_en(wr), .mem_wdata(mwd), .mem_rdata(mrd));
    // ----------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One idle edge first, so release and next setup never share a step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin err_count++; print_verdict(); end
    endtask
    // Issue one word, wait for idle, compare ACC, FLAGS and memory
    task automatic exec_op(input logic [15:0] ins, input logic [11:0] ea);
        logic [7:0] m, w, r;
        logic [4:0] f, fe, h;
        logic [8:0] d;
        int n = 0;
        apb(1'b0, exec_pkg::ACC_OFFSET, 32'h0);
        w = q[7:0];
        apb(1'b0, exec_pkg::FLAGS_OFFSET, 32'h0);
        f = q[4:0];
        m = data_mem_model_i.mem[ea];
        d = {1'b0, m} - {1'b0, w} - {8'h00, ~f[0]};
        h = {1'b0, m[3:0]} - {1'b0, w[3:0]} - {4'h0, ~f[0]};
        r = (ins[15:10] == 6'h16) ? d[7:0] : {m[3:0], m[7:4]};
        fe = (ins[15:10] == 6'h16) ? {r[7], (m[7] ^ w[7]) & (r[7] ^ m[7]),
            r == 8'h00, ~h[4], ~d[8]} : f;
        apb(1'b1, exec_pkg::INSTR_OFFSET, {16'h0, ins});
        do begin
            apb(1'b0, exec_pkg::STATUS_OFFSET, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 16);
        if (q[0] !== 1'b0) begin err_count++; print_verdict(); end
        apb(1'b0, exec_pkg::ACC_OFFSET, 32'h0);
        chk(q, {24'h0, ins[9] ? w : r});
        apb(1'b0, exec_pkg::FLAGS_OFFSET, 32'h0);
        chk(q, {27'h0, fe});
        chk({24'h0, data_mem_model_i.mem[ea]}, {24'h0, ins[9] ? r : m});
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Every register must read zero after reset
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(i * 4), 32'hFFFF_FFFF);
            chk(q, 32'h0);
            chk({31'h0, e}, 32'h0);
        end
        // Unmapped word answers with an error and reads zero
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        apb(1'b1, exec_pkg::CTRL_OFFSET, 32'h300);
        apb(1'b1, exec_pkg::ACC_OFFSET, 32'h0D);
        apb(1'b1, exec_pkg::FLAGS_OFFSET, 32'h01);
        exec_op({6'h16, 2'h1, 8'hC4}, 12'h3C4);
        exec_op({6'h16, 2'h2, 8'h70}, 12'hF70);
        apb(1'b1, exec_pkg::FLAGS_OFFSET, 32'h00);
        exec_op({6'h16, 2'h2, 8'h12}, 12'h012);
        apb(1'b1, exec_pkg::STACK_BASE_OFFSET, 32'h200);
        apb(1'b1, exec_pkg::CTRL_OFFSET, 32'hF01);
        exec_op({6'h0E, 2'h2, 8'h5F}, 12'h25F);
        exec_op({6'h0E, 2'h0, 8'h60}, 12'hF60);
        exec_op({6'h0E, 2'h1, 8'hFF}, 12'hFFF);
        // A word matching neither opcode is flagged, not executed
        apb(1'b1, exec_pkg::INSTR_OFFSET, 32'hFFFF);
        repeat (4) @(posedge pclk);
        apb(1'b0, exec_pkg::STATUS_OFFSET, 32'h0);
        chk(q, 32'h2);
        print_verdict();
    end
endmodule
`default_nettype wire
